// ==== pkg/spe_cfg.svh ====
`ifndef SPE_CFG_SVH
`define SPE_CFG_SVH

// Command pointer codes (register index)
`define SPE_OFF_LEVEL0 3'h0
`define SPE_OFF_LEVEL1 3'h1
`define SPE_OFF_DRIVE0 3'h2
`define SPE_OFF_DRIVE1 3'h3
`define SPE_OFF_INVERT0 3'h4
`define SPE_OFF_INVERT1 3'h5
`define SPE_OFF_DIR0 3'h6
`define SPE_OFF_DIR1 3'h7

// Command byte fields: pointer in the low bits, bit 0 picks the member of a pair
`define SPE_PTR_LSB 0
`define SPE_PTR_MSB 2
`define SPE_PAIR_BIT 0

// Reset values
`define SPE_RST_DRIVE 8'hFF
`define SPE_RST_INVERT 8'h00
`define SPE_RST_DIR 8'hFF

// Fixed upper slave address bits, straps fill the low three
`define SPE_ADDR_FIXED 4'h4

// Spike filter timing
`define SPE_SPIKE_NS 50
`define SPE_CLK_NS 50
`define SPE_FILT_CYC ((`SPE_SPIKE_NS + `SPE_CLK_NS - 1) / `SPE_CLK_NS)

// Bits in a byte
`define SPE_BYTE_BITS 4'h8
`define SPE_LAST_BIT 4'h7

`endif

// ==== pkg/spe_pkg.sv ====
package spe_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RECV = 3'b001,
        ST_ACK = 3'b010,
        ST_SEND = 3'b011,
        ST_MACK = 3'b100
    } spe_state_type;

    typedef enum logic [1:0] {
        PH_ADDR = 2'b00,
        PH_CMD = 2'b01,
        PH_DATA = 2'b10
    } spe_phase_type;

    typedef struct packed {
        logic [15:0] pin_m;
        logic [15:0] pin_s;
        logic scl_m;
        logic scl_s;
        logic scl_f;
        logic scl_p;
        logic [3:0] scl_c;
        logic sda_m;
        logic sda_s;
        logic sda_f;
        logic sda_p;
        logic [3:0] sda_c;
        logic [2:0] strap_m;
        logic [2:0] strap_s;
        spe_state_type state;
        spe_phase_type phase;
        logic rw;
        logic ack;
        logic [3:0] cnt;
        logic [7:0] shift;
        logic [2:0] ptr;
        logic [1:0][7:0] drive;
        logic [1:0][7:0] invert;
        logic [1:0][7:0] dir;
        logic [15:0] snap;
        logic [1:0] prime;
        logic sda_oe;
        logic int_oe;
        logic [15:0] pin_out;
        logic [15:0] pin_oe;
    } spe_state_struct_type;

endpackage

// ==== src/spe_port_expander.sv ====
// Functional notes
// - Level registers always return sampled pin levels, whatever the pin direction.
// - Level registers are read-only; writes to them change nothing.
// - Output-direction pins are driven with their drive latch bit.
// - Drive latch bits of input pins are kept but never reach the pin.
// - Reading a drive latch returns the stored value, not the pin.
// - Invert bit one stores the complemented level for input pins.
// - Invert bit zero stores the true pin level.
// - Direction bit one makes the pin a high-impedance input.
// - Direction bit zero enables the pin driver from the drive latch.
// - Drive latches reset to all ones.
// - Invert registers reset to all zeros.
// - Serial clock and data spikes up to 50 ns are filtered out.
// - Command byte after address loads write-only pointer; low three bits select register.
// - Burst transfers alternate between the two registers of a pair, unlimited.
// - Input pin edge asserts interrupt; clears on return or port read.
// - Direction registers reset to all ones, all pins inputs.
`timescale 1ns/10ps
`default_nettype none
`include "spe_cfg.svh"

module spe_port_expander
    import spe_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic [2:0] addr_strap_in,
    input wire logic [7:0] port0_pin_in,
    output logic [7:0] port0_pin_out,
    output logic [7:0] port0_pin_oe_out,
    input wire logic [7:0] port1_pin_in,
    output logic [7:0] port1_pin_out,
    output logic [7:0] port1_pin_oe_out,
    output logic int_n_out,
    output logic int_oe_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Spike filter: a new level must persist FILT_CYC+1 samples to be accepted

    localparam logic [3:0] FILT_CYC = 4'(`SPE_FILT_CYC);

    function automatic logic [4:0] glitch_step(input logic s, input logic f, input logic [3:0] c);
        logic [4:0] r;
        r = {f, 4'h0};
        if (s != f) begin
            if (c >= FILT_CYC) begin
                r = {s, 4'h0};
            end else begin
                r = {f, 4'(c + 4'h1)};
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State

    spe_state_struct_type q, d;
    logic scl_rise, scl_fall, bus_start, bus_stop;
    logic [15:0] dir_all, level_w;
    logic [7:0] rd_byte;

    // Bus events from the filtered lines only.
    // Both lines share one pipeline, so their relative timing is kept; the cost is about five
    // clocks of latency, which limits how short the SCL low half may be for our own SDA moves.
    assign scl_rise = q.scl_f & ~q.scl_p;
    assign scl_fall = ~q.scl_f & q.scl_p;
    assign bus_start = q.scl_f & q.scl_p & q.sda_p & ~q.sda_f;
    assign bus_stop = q.scl_f & q.scl_p & ~q.sda_p & q.sda_f;

    // Level value seen by the host; inversion only acts on input pins
    assign dir_all = {q.dir[1], q.dir[0]};
    assign level_w = q.pin_s ^ ({q.invert[1], q.invert[0]} & dir_all);

    // Read multiplexer; pair bit selects port, so index 0 is port 0
    always_comb begin
        unique case (q.ptr[2:1])
            2'b00: rd_byte = q.ptr[`SPE_PAIR_BIT] ? level_w[15:8] : level_w[7:0];
            2'b01: rd_byte = q.drive[q.ptr[`SPE_PAIR_BIT]];
            2'b10: rd_byte = q.invert[q.ptr[`SPE_PAIR_BIT]];
            2'b11: rd_byte = q.dir[q.ptr[`SPE_PAIR_BIT]];
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb begin
        d = q;
        // Two-flop synchronisers for every pin input
        d.pin_m = {port1_pin_in, port0_pin_in};
        d.pin_s = q.pin_m;
        d.scl_m = scl_in;
        d.scl_s = q.scl_m;
        d.sda_m = sda_in;
        d.sda_s = q.sda_m;
        d.strap_m = addr_strap_in;
        d.strap_s = q.strap_m;
        {d.scl_f, d.scl_c} = glitch_step(q.scl_s, q.scl_f, q.scl_c);
        {d.sda_f, d.sda_c} = glitch_step(q.sda_s, q.sda_f, q.sda_c);
        d.scl_p = q.scl_f;
        d.sda_p = q.sda_f;

        // Reference levels follow the pins until the synchronisers hold real data
        if (q.prime != 2'h3) begin
            d.prime = 2'(q.prime + 2'h1);
            d.snap = q.pin_s;
        end

        // Pin drivers: enable only where direction bit is zero
        d.pin_out = {q.drive[1], q.drive[0]};
        d.pin_oe = ~dir_all;

        // Interrupt: any input pin differing from its last-read level; output pins never count
        d.int_oe = (q.prime == 2'h3) && (|((q.pin_s ^ q.snap) & dir_all));

        // Serial slave
        if (bus_start) begin
            d.state = ST_RECV;
            d.phase = PH_ADDR;
            d.cnt = 4'h0;
            d.sda_oe = 1'b0;
        end else if (bus_stop) begin
            d.state = ST_IDLE;
            d.sda_oe = 1'b0;
        end else begin
            unique case (q.state)
                ST_IDLE: begin
                    d.sda_oe = 1'b0;
                end
                ST_RECV: begin
                    if (scl_rise) begin
                        d.shift = {q.shift[6:0], q.sda_f};
                        d.cnt = 4'(q.cnt + 4'h1);
                    end else if (scl_fall && q.cnt == `SPE_BYTE_BITS) begin
                        d.state = ST_ACK;
                        d.sda_oe = 1'b1;
                        unique case (q.phase)
                            PH_ADDR: begin
                                // Foreign address: let go of the bus until the next start
                                if (q.shift[7:1] != {`SPE_ADDR_FIXED, q.strap_s}) begin
                                    d.state = ST_IDLE;
                                    d.sda_oe = 1'b0;
                                end
                                d.rw = q.shift[0];
                            end
                            PH_CMD: begin
                                d.ptr = q.shift[`SPE_PTR_MSB:`SPE_PTR_LSB];
                            end
                            default: begin
                                // Level registers swallow the byte, nothing changes
                                unique case (q.ptr[2:1])
                                    2'b00: ;
                                    2'b01: d.drive[q.ptr[`SPE_PAIR_BIT]] = q.shift;
                                    2'b10: d.invert[q.ptr[`SPE_PAIR_BIT]] = q.shift;
                                    2'b11: d.dir[q.ptr[`SPE_PAIR_BIT]] = q.shift;
                                endcase
                                d.ptr[`SPE_PAIR_BIT] = ~q.ptr[`SPE_PAIR_BIT];
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        d.cnt = 4'h0;
                        if (q.phase == PH_ADDR && q.rw) begin
                            // Byte is frozen at load so a changing pin cannot tear it
                            d.state = ST_SEND;
                            d.shift = rd_byte;
                            d.sda_oe = ~rd_byte[7];
                        end else begin
                            d.state = ST_RECV;
                            d.sda_oe = 1'b0;
                            d.phase = (q.phase == PH_ADDR) ? PH_CMD : PH_DATA;
                        end
                    end
                end
                ST_SEND: begin
                    if (scl_fall) begin
                        if (q.cnt == `SPE_LAST_BIT) begin
                            d.state = ST_MACK;
                            d.sda_oe = 1'b0;
                        end else begin
                            d.shift = {q.shift[6:0], 1'b0};
                            d.sda_oe = ~q.shift[6];
                            d.cnt = 4'(q.cnt + 4'h1);
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        d.ack = ~q.sda_f;
                        // Port read completes here: new reference clears its interrupt
                        if (q.ptr[2:1] == 2'b00) begin
                            if (q.ptr[`SPE_PAIR_BIT]) begin
                                d.snap[15:8] = q.pin_s[15:8];
                            end else begin
                                d.snap[7:0] = q.pin_s[7:0];
                            end
                        end
                        d.ptr[`SPE_PAIR_BIT] = ~q.ptr[`SPE_PAIR_BIT];
                    end else if (scl_fall) begin
                        d.cnt = 4'h0;
                        if (q.ack) begin
                            d.state = ST_SEND;
                            d.shift = rd_byte;
                            d.sda_oe = ~rd_byte[7];
                        end else begin
                            d.state = ST_IDLE;
                        end
                    end
                end
                default: begin
                    d.state = ST_IDLE;
                    d.sda_oe = 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register; reset takes constants only

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            q <= '0;
            q.scl_m <= 1'b1;
            q.scl_s <= 1'b1;
            q.scl_f <= 1'b1;
            q.scl_p <= 1'b1;
            q.sda_m <= 1'b1;
            q.sda_s <= 1'b1;
            q.sda_f <= 1'b1;
            q.sda_p <= 1'b1;
            q.state <= ST_IDLE;
            q.phase <= PH_ADDR;
            q.drive <= {`SPE_RST_DRIVE, `SPE_RST_DRIVE};
            q.invert <= {`SPE_RST_INVERT, `SPE_RST_INVERT};
            q.dir <= {`SPE_RST_DIR, `SPE_RST_DIR};
            q.pin_out <= {`SPE_RST_DRIVE, `SPE_RST_DRIVE};
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from flops; open-drain lines only ever pull low

    assign sda_out = q.shift[7] & 1'b0;
    assign sda_oe_out = q.sda_oe;
    assign port0_pin_out = q.pin_out[7:0];
    assign port0_pin_oe_out = q.pin_oe[7:0];
    assign port1_pin_out = q.pin_out[15:8];
    assign port1_pin_oe_out = q.pin_oe[15:8];
    assign int_n_out = ~q.int_oe & 1'b0;
    assign int_oe_out = q.int_oe;

endmodule
`default_nettype wire

// ==== tb/spe_i2c_host.sv ====
`timescale 1ns/10ps
`default_nettype none
// Bus master model: SDA pulled low only, SCL timed in quarter bits of the reference clock
module spe_i2c_host (
    input wire logic clk_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_low_out
);
    int q = 2; // 2 gives the 400 ns bit; the bench raises it to act as a slow master
    // Idle bus: SCL high, SDA released
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    task automatic w(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    // Data moves only while SCL is low; sampled at the end of the high half.
    // The low half is q+2 cycles longer than the high half because the slave sees SCL fall
    // about five clocks late (sync plus filter), and it must move SDA before SCL rises again.
    task automatic bit_io(input logic b, output logic r);
        sda_low_out <= ~b;
        w(q + 2);
        scl_out <= 1'b1;
        w(q);
        r = sda_in;
        scl_out <= 1'b0;
        w(q);
    endtask
    // Start and repeated start: SDA falls while SCL is high
    task automatic start();
        sda_low_out <= 1'b0;
        w(q + 2);
        scl_out <= 1'b1;
        w(2 * q);
        sda_low_out <= 1'b1;
        w(2 * q);
        scl_out <= 1'b0;
        w(q);
    endtask
    task automatic stop();
        sda_low_out <= 1'b1;
        w(q + 2);
        scl_out <= 1'b1;
        w(2 * q);
        sda_low_out <= 1'b0;
        w(2 * q);
    endtask
    // One byte MSB first, then a released ninth bit that samples the slave ACK
    task automatic wr_byte(input logic [7:0] d, output logic ack_n);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], ack_n);
        end
        bit_io(1'b1, ack_n);
    endtask
    // NACK on the last byte ends a read burst
    task automatic rd_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(last, r);
    endtask
endmodule
`default_nettype wire

// ==== tb/spe_port_expander_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
module spe_port_expander_sva (
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe_out,
    input wire logic [7:0] port0_pin_in,
    input wire logic [7:0] port0_pin_out,
    input wire logic [7:0] port0_pin_oe_out,
    input wire logic [7:0] port1_pin_in,
    input wire logic [7:0] port1_pin_out,
    input wire logic [7:0] port1_pin_oe_out,
    input wire logic int_n_out,
    input wire logic int_oe_out
);
    wire logic [31:0] outs = {port0_pin_oe_out, port1_pin_oe_out, port0_pin_out, port1_pin_out};
    wire logic [31:0] pins = {port0_pin_in, port1_pin_in, port0_pin_oe_out, port1_pin_oe_out};
    logic scl_q;
    logic [31:0] pins_q;
    logic [4:0] scl_quiet_q;
    logic [4:0] pin_quiet_q;
    // Saturating ages of the last SCL and pin moves; a long SCL-high age means an idle bus
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            scl_q <= 1'b1;
            pins_q <= 32'h00000000;
            scl_quiet_q <= 5'h00;
            pin_quiet_q <= 5'h00;
        end else begin
            scl_q <= scl_in;
            pins_q <= pins;
            scl_quiet_q <= (scl_in != scl_q) ? 5'h00 : scl_quiet_q + {4'h0, scl_quiet_q != 5'h1F};
            pin_quiet_q <= (pins != pins_q) ? 5'h00 : pin_quiet_q + {4'h0, pin_quiet_q != 5'h1F};
        end
    end
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rstn_in);
    property p_sda_od; sda_out == 1'b0; endproperty
    a_sda_od: assert property (p_sda_od) else $error("sda data high");
    property p_int_od; int_n_out == 1'b0; endproperty
    a_int_od: assert property (p_int_od) else $error("int data high");
    property p_rst_out; $rose(rstn_in) |-> outs == 32'h0000FFFF; endproperty
    a_rst_out: assert property (p_rst_out) else $error("reset outputs");
    property p_rst_int; $rose(rstn_in) |-> (!int_oe_out) [*3]; endproperty
    a_rst_int: assert property (p_rst_int) else $error("int after reset");
    property p_idle_out; scl_quiet_q >= 5'h10 |-> $stable(outs); endproperty
    a_idle_out: assert property (p_idle_out) else $error("pins moved on idle bus");
    property p_idle_sda; scl_quiet_q >= 5'h10 |-> !sda_oe_out; endproperty
    a_idle_sda: assert property (p_idle_sda) else $error("sda held on idle bus");
    property p_int_rise; $rose(int_oe_out) |-> pin_quiet_q < 5'h0C; endproperty
    a_int_rise: assert property (p_int_rise) else $error("int without pin change");
    property p_int_fall; $fell(int_oe_out) |-> pin_quiet_q < 5'h0C || scl_quiet_q < 5'h0C; endproperty
    a_int_fall: assert property (p_int_fall) else $error("int cleared without cause");
    c_int: cover property ($rose(int_oe_out));
    c_ack: cover property ($rose(sda_oe_out));
    c_out: cover property ($changed(outs));
endmodule
`default_nettype wire

// ==== tb/spe_port_expander_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module spe_port_expander_tb;
    localparam logic [7:0] DEV_W = 8'h4A; // Straps 101 under the fixed 0100
    localparam logic [7:0] DEV_R = 8'h4B;
    logic ref_clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [7:0] ext0 = 8'h00;
    logic [7:0] ext1 = 8'h96;
    logic host_low, scl_w, sda_o, sda_oe, int_n, int_oe, ack_n;
    logic [7:0] p0_out, p0_oe, p1_out, p1_oe, d0, d1;
    int n_fail = 0;
    int check_count = 0;
    logic [7:0] rst_exp [3] = '{8'hFF, 8'h00, 8'hFF};
    // Command, written byte, expected read back
    logic [23:0] rows [8] = '{24'h02A5A5, 24'h033C3C, 24'h040F0F, 24'h05F0F0, 24'h060000, 24'h07FFFF,
        24'h0012A5, 24'h017766};
    // Pulled-up SDA; every pin has an outside driver so none floats
    wire logic sda_w = ~(host_low | sda_oe);
    wire logic [7:0] pin0 = (p0_oe & p0_out) | (~p0_oe & ext0);
    wire logic [7:0] pin1 = (p1_oe & p1_out) | (~p1_oe & ext1);
    spe_i2c_host u_host (.clk_in(ref_clk_in), .sda_in(sda_w), .scl_out(scl_w), .sda_low_out(host_low));
    spe_port_expander u_dut (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .scl_in(scl_w), .sda_in(sda_w),
        .sda_out(sda_o), .sda_oe_out(sda_oe), .addr_strap_in(3'h5), .port0_pin_in(pin0), .port0_pin_out(p0_out),
        .port0_pin_oe_out(p0_oe), .port1_pin_in(pin1), .port1_pin_out(p1_out), .port1_pin_oe_out(p1_oe),
        .int_n_out(int_n), .int_oe_out(int_oe));
    ////////////////////////////////////////
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s exp %h got %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] cmd, input logic [23:0] d, input int n);
        u_host.start();
        u_host.wr_byte(DEV_W, ack_n);
        chk("address ack", 8'h00, {7'h00, ack_n});
        u_host.wr_byte(cmd, ack_n);
        for (int i = 0; i < n; i++) begin
            u_host.wr_byte(d[23 - 8 * i -: 8], ack_n);
        end
        u_host.stop();
    endtask
    // Repeated start keeps the pointer; two bytes read, the second one NACKed
    task automatic rd(input logic [7:0] cmd);
        u_host.start();
        u_host.wr_byte(DEV_W, ack_n);
        u_host.wr_byte(cmd, ack_n);
        u_host.start();
        u_host.wr_byte(DEV_R, ack_n);
        u_host.rd_byte(1'b0, d0);
        u_host.rd_byte(1'b1, d1);
        u_host.stop();
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        forever #25 ref_clk_in = ~ref_clk_in;
    end
    // A full run takes well under a millisecond
    initial begin
        #2000000;
        n_fail++;
        report_and_stop();
    end
    initial begin
        repeat (8) @(posedge ref_clk_in);
        rstn_in <= 1'b1;
        repeat (8) @(posedge ref_clk_in);
        for (int i = 0; i < 3; i++) begin
            rd(8'(2 * i + 2));
            chk("reset value", rst_exp[i], d0);
            chk("reset partner", rst_exp[i], d1);
        end
        chk("reset enables", 8'h00, p0_oe | p1_oe);
        $display("test reset done");
        foreach (rows[i]) begin
            wr(rows[i][23:16], {rows[i][15:8], 16'h0000}, 1);
            rd(rows[i][23:16]);
            chk("readback", rows[i][7:0], d0);
        end
        chk("port0 drive", 8'hA5, p0_out);
        chk("enables", 8'h00, p1_oe | ~p0_oe);
        chk("port1 latch", 8'h3C, p1_out);
        $display("test table done");
        wr(8'hFB, 24'h112233, 3);
        rd(8'h02);
        chk("burst", 8'h22, d0);
        chk("burst partner", 8'h33, d1);
        chk("port0 pins", 8'h22, p0_out);
        u_host.q = 6;
        rd(8'h03);
        chk("slow read", 8'h33, d0);
        u_host.q = 2;
        u_host.start();
        u_host.wr_byte(8'h40, ack_n);
        u_host.stop();
        chk("foreign address", 8'h01, {7'h00, ack_n});
        $display("test burst done");
        rd(8'h00);
        ext1 <= 8'h97;
        repeat (12) @(posedge ref_clk_in);
        chk("int on edge", 8'h01, {7'h00, int_oe});
        ext1 <= 8'h96;
        repeat (12) @(posedge ref_clk_in);
        chk("int on return", 8'h00, {7'h00, int_oe});
        ext1 <= 8'h16;
        repeat (12) @(posedge ref_clk_in);
        rd(8'h01);
        chk("int after read", 8'h00, {7'h00, int_oe});
        chk("inverted level", 8'hE6, d0);
        $display("test interrupt done");
        report_and_stop();
    end
endmodule
bind spe_port_expander spe_port_expander_sva u_sva (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
    .scl_in(scl_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out), .port0_pin_in(port0_pin_in),
    .port0_pin_out(port0_pin_out), .port0_pin_oe_out(port0_pin_oe_out), .port1_pin_in(port1_pin_in),
    .port1_pin_out(port1_pin_out), .port1_pin_oe_out(port1_pin_oe_out), .int_n_out(int_n_out),
    .int_oe_out(int_oe_out));
`default_nettype wire
